// ==== hw/usb_control_register_logic.sv ====
// usb control register logic: control bits, live line flags, interrupts
// Notes on behaviour
// R1: bit 7 reads high while a j state is on the lines.
// R2: bit 6 reads high while both data lines are low.
// R3: device role: bit 5 halts packets, set by hardware on setup token.
// R4: host role: bit 5 reads high while a token executes.
// R5: software waits for token idle before writing a new token.
// R6: host role: bit 4 set drives bus reset signalling.
// R7: bit 3 enables host capability.
// R8: any change of host enable resets all host control logic; the code resets only the token engine and bit 5, not the line driver.
// R9: bit 2 set drives resume; clear drives none.
// R10: software holds resume 10 ms as function, 25 ms as host.
// R11: host role: clearing resume appends a low speed end of packet.
// R12: bits 31 to 8 ignore writes and read zero.
// R13: bit 1 resets ping-pong pointers to even; bit 0 enables module or frames.
`default_nettype none
`include "usb_ctl_cfg.svh"
module usb_control_register_logic
  import usb_ctl_pkg::*;
#(
  parameter int TOKEN_CYCLES = `TOKEN_CYCLES,
  parameter int EOP_CYCLES   = `LS_EOP_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_dp,
  input  wire logic        i_dm,
  input  wire logic        i_low_speed,
  input  wire logic        i_setup_rx,
  output logic             o_dp,
  output logic             o_dm,
  output logic             o_oe,
  output logic             o_irq,
  output logic             o_module_enable,
  output logic             o_frame_start_enable,
  output logic             o_packet_processing_disable,
  output logic             o_pingpong_pointer_reset,
  output logic             o_host_role_enable
);
  logic [7:0]      ctrl;
  logic [7:0]      token_command;
  logic            live_j_level_flag;
  logic            live_se0;
  logic            host_prev;
  logic            host_clear;
  logic            token_start;
  logic            token_in_progress;
  logic            token_done;
  logic [7:0]      last_token;
  logic            eop_done;
  logic            line_dp;
  logic            line_dm;
  logic            line_oe;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;
  logic [`IRQ_W-1:0] irq_event;
  logic [`IRQ_W-1:0] irq_clear;
  logic [31:0]     next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  wire logic host  = ctrl[`BIT_HOST_EN];
  wire logic wr_ctrl = i_wr && hit(i_addr, `ADDR_USB_CONTROL);

  // live flags; j is d+ high at full speed, d- high at low speed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live_j_level_flag <= 1'b0;
      live_se0          <= 1'b0;
    end else begin
      live_j_level_flag <= i_low_speed ? (i_dm && !i_dp) : (i_dp && !i_dm); // R1
      live_se0          <= !i_dp && !i_dm; // R2
    end
  end

  // control register; only the low byte is stored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl[`BIT_BUS_RESET:`BIT_MOD_EN] <= i_wdata[`BIT_BUS_RESET:`BIT_MOD_EN]; // R7 R12
        if (!host) begin
          ctrl[`BIT_PKT_DIS] <= i_wdata[`BIT_PKT_DIS];
        end
      end
      // host toggle clears; a setup in the same cycle still wins, as over software
      if (host_clear) begin
        ctrl[`BIT_PKT_DIS] <= 1'b0; // R8
      end
      if (!host && i_setup_rx) begin
        ctrl[`BIT_PKT_DIS] <= 1'b1; // R3
      end
    end
  end

  // host enable edge detector: either direction resets host logic
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_prev <= 1'b0;
    end else begin
      host_prev <= host;
    end
  end
  assign host_clear = host ^ host_prev; // R8

  // token command register; software must poll busy first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      token_command <= 8'h00;
      token_start   <= 1'b0;
    end else begin
      token_start <= 1'b0;
      if (i_wr && hit(i_addr, `ADDR_TOKEN_COMMAND) && host && !token_in_progress) begin
        token_command <= i_wdata[7:0]; // R5
        token_start   <= 1'b1;
      end
    end
  end

  usb_token_engine #(
    .TOKEN_CYCLES(TOKEN_CYCLES)
  ) u_token (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_host_clear (host_clear || !host),
    .i_start      (token_start),
    .i_token      (token_command),
    .o_busy       (token_in_progress),
    .o_done       (token_done),
    .o_last_token (last_token)
  );

  usb_line_driver #(
    .EOP_CYCLES(EOP_CYCLES)
  ) u_line (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_host      (host),
    .i_bus_reset (ctrl[`BIT_BUS_RESET]), // R6
    .i_resume    (ctrl[`BIT_RESUME]), // R9 R10
    .o_dp        (line_dp),
    .o_dm        (line_dm),
    .o_oe        (line_oe),
    .o_eop_done  (eop_done)
  );

  // interrupt events
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_SETUP]       = !host && i_setup_rx;
    irq_event[`IRQ_TOKEN_DONE]  = token_done;
    irq_event[`IRQ_HOST_TOGGLE] = host_clear;
    irq_event[`IRQ_RESUME_END]  = eop_done; // R11
    irq_clear = '0;
    if (i_wr && hit(i_addr, `ADDR_IRQ_CLEAR)) begin
      irq_clear = i_wdata[`IRQ_W-1:0];
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= '0;
    end else if (i_wr && hit(i_addr, `ADDR_IRQ_ENABLE)) begin
      irq_enable <= i_wdata[`IRQ_W-1:0];
    end
  end

  // read mux; bit 5 shows token busy in host role
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(i_addr, `ADDR_USB_CONTROL)) begin
      next_rdata[7:0] = ctrl; // R12
      next_rdata[`BIT_J_LEVEL] = live_j_level_flag;
      next_rdata[`BIT_SE0]     = live_se0;
      next_rdata[`BIT_PKT_DIS] = host ? token_in_progress : ctrl[`BIT_PKT_DIS]; // R4
    end else if (hit(i_addr, `ADDR_TOKEN_COMMAND)) begin
      next_rdata[7:0] = last_token;
    end else if (hit(i_addr, `ADDR_IRQ_STATUS)) begin
      next_rdata[`IRQ_W-1:0] = irq_status;
    end else if (hit(i_addr, `ADDR_IRQ_ENABLE)) begin
      next_rdata[`IRQ_W-1:0] = irq_enable;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq                       <= 1'b0;
      o_dp                        <= 1'b0;
      o_dm                        <= 1'b0;
      o_oe                        <= 1'b0;
      o_module_enable             <= 1'b0;
      o_frame_start_enable        <= 1'b0;
      o_packet_processing_disable <= 1'b0;
      o_pingpong_pointer_reset    <= 1'b0;
      o_host_role_enable          <= 1'b0;
    end else begin
      o_irq                       <= |(irq_status & irq_enable);
      o_dp                        <= line_dp;
      o_dm                        <= line_dm;
      o_oe                        <= line_oe;
      o_module_enable             <= !host && ctrl[`BIT_MOD_EN]; // R13
      o_frame_start_enable        <= host && ctrl[`BIT_MOD_EN];
      o_packet_processing_disable <= !host && ctrl[`BIT_PKT_DIS]; // R3
      o_pingpong_pointer_reset    <= ctrl[`BIT_PP_RESET]; // R13
      o_host_role_enable          <= host; // R7
    end
  end
endmodule : usb_control_register_logic
`default_nettype wire

// ==== hw/usb_ctl_cfg.svh ====
// register offsets, field positions, reset values and timing counts of the usb control block
`ifndef USB_CTL_CFG_SVH
`define USB_CTL_CFG_SVH
`define ADDR_USB_CONTROL      8'h00
`define ADDR_TOKEN_COMMAND    8'h04
`define ADDR_IRQ_STATUS       8'h08
`define ADDR_IRQ_ENABLE       8'h0C
`define ADDR_IRQ_CLEAR        8'h10
`define BIT_J_LEVEL           7
`define BIT_SE0               6
`define BIT_PKT_DIS           5
`define BIT_BUS_RESET         4
`define BIT_HOST_EN           3
`define BIT_RESUME            2
`define BIT_PP_RESET          1
`define BIT_MOD_EN            0
`define CTRL_RESET            8'h00
`define IRQ_SETUP             0
`define IRQ_TOKEN_DONE        1
`define IRQ_HOST_TOGGLE       2
`define IRQ_RESUME_END        3
`define IRQ_W                 4
`define LS_EOP_NS             1330
`define CLK_NS                40
`define LS_EOP_CYCLES         ((`LS_EOP_NS + `CLK_NS - 1) / `CLK_NS)
`define TOKEN_CYCLES          16
`endif

// ==== hw/usb_ctl_pkg.sv ====
// types shared by the usb control block
`default_nettype none
package usb_ctl_pkg;
  typedef enum logic [2:0] {
    LN_IDLE   = 3'b001,
    LN_RESUME = 3'b010,
    LN_EOP    = 3'b100
  } line_state_t;
  typedef enum logic [1:0] {
    TK_IDLE = 2'b01,
    TK_BUSY = 2'b10
  } token_state_t;
endpackage : usb_ctl_pkg
`default_nettype wire

// ==== hw/usb_line_driver.sv ====
// line driver: bus reset, resume and low speed end of packet on d+/d-
`default_nettype none
`include "usb_ctl_cfg.svh"
module usb_line_driver
  import usb_ctl_pkg::*;
#(
  parameter int EOP_CYCLES = `LS_EOP_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_host,
  input  wire logic i_bus_reset,
  input  wire logic i_resume,
  output logic      o_dp,
  output logic      o_dm,
  output logic      o_oe,
  output logic      o_eop_done
);
  line_state_t      state;
  logic      [15:0] cnt;

  // resume, then in host role a low speed end of packet after the bit clears
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= LN_IDLE;
      cnt        <= 16'h0000;
      o_eop_done <= 1'b0;
    end else begin
      o_eop_done <= 1'b0;
      case (state)
        LN_IDLE: begin
          if (i_resume) state <= LN_RESUME;
        end
        LN_RESUME: begin
          if (!i_resume) begin
            if (i_host) begin
              state <= LN_EOP; // R11
              cnt   <= 16'h0000;
            end else begin
              state      <= LN_IDLE;
              o_eop_done <= 1'b1;
            end
          end
        end
        LN_EOP: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(EOP_CYCLES - 1)) begin
            state      <= LN_IDLE;
            o_eop_done <= 1'b1;
          end
        end
        default: state <= LN_IDLE;
      endcase
    end
  end

  // bus reset in host role drives se0; resume drives low speed k (d+ high, d- low); eop is se0
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_oe <= 1'b0;
    end else if (i_host && i_bus_reset) begin
      o_dp <= 1'b0; // R6
      o_dm <= 1'b0;
      o_oe <= 1'b1;
    end else if (state == LN_RESUME && i_resume) begin
      o_dp <= 1'b1; // R9
      o_dm <= 1'b0;
      o_oe <= 1'b1;
    end else if (state == LN_EOP || (state == LN_RESUME && i_host)) begin
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_oe <= 1'b1;
    end else begin
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_oe <= 1'b0; // R9
    end
  end
endmodule : usb_line_driver
`default_nettype wire

// ==== hw/usb_token_engine.sv ====
// host token executor: busy while a token runs for a fixed time
`default_nettype none
`include "usb_ctl_cfg.svh"
module usb_token_engine
  import usb_ctl_pkg::*;
#(
  parameter int TOKEN_CYCLES = `TOKEN_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_host_clear,
  input  wire logic       i_start,
  input  wire logic [7:0] i_token,
  output logic            o_busy,
  output logic            o_done,
  output logic      [7:0] o_last_token
);
  token_state_t      state;
  logic       [15:0] cnt;

  // a clear from the host role toggle aborts any token in flight
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= TK_IDLE;
      cnt          <= 16'h0000;
      o_done       <= 1'b0;
      o_last_token <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (i_host_clear) begin
        state        <= TK_IDLE; // R8
        cnt          <= 16'h0000;
        o_last_token <= 8'h00;
      end else begin
        case (state)
          TK_IDLE: begin
            if (i_start) begin
              state        <= TK_BUSY;
              cnt          <= 16'h0000;
              o_last_token <= i_token;
            end
          end
          TK_BUSY: begin
            cnt <= cnt + 16'h0001;
            if (cnt == 16'(TOKEN_CYCLES - 1)) begin
              state  <= TK_IDLE;
              o_done <= 1'b1;
            end
          end
          default: state <= TK_IDLE;
        endcase
      end
    end
  end

  assign o_busy = (state == TK_BUSY); // R4
endmodule : usb_token_engine
`default_nettype wire

// ==== bench/usb_ctl_monitor.sv ====
// checker for the usb control register block, bound to its ports
`default_nettype none
module usb_ctl_monitor #(
  parameter int EOP_CYCLES = 34
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_dp,
  input wire logic        i_dm,
  input wire logic        i_low_speed,
  input wire logic        i_setup_rx,
  input wire logic        o_dp,
  input wire logic        o_dm,
  input wire logic        o_oe,
  input wire logic        o_module_enable,
  input wire logic        o_frame_start_enable,
  input wire logic        o_packet_processing_disable,
  input wire logic        o_host_role_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EOP_MAX = EOP_CYCLES + 8;
  logic       hst, brst, res, en, bon, jexp, se0exp, steady;
  logic [2:0] p1, p2, rc;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // shadow of the software-written control bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {hst, brst, res, en} <= 4'h0;
    end else if (i_wr && i_addr == 8'h00) begin
      {hst, brst, res, en} <= {i_wdata[3], i_wdata[4], i_wdata[2], i_wdata[0]};
    end
  end
  // pin history: flags lag the pins, so judge them only on settled lines
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p1 <= 3'h0;
      p2 <= 3'h0;
      rc <= 3'h0;
    end else begin
      p1 <= {i_low_speed, i_dp, i_dm};
      p2 <= p1;
      rc <= (res && !brst) ? rc + {2'h0, rc != 3'h7} : 3'h0;
    end
  end
  assign steady = ({i_low_speed, i_dp, i_dm} == p1) && (p1 == p2);
  assign jexp   = i_low_speed ? (!i_dp && i_dm) : (i_dp && !i_dm);
  assign se0exp = !i_dp && !i_dm;
  assign bon    = hst && brst && !res;
  AST_J_FLAG: assert property (i_rd && i_addr == 8'h00 && steady |=> o_rdata[7] == $past(jexp))
    else $error("j flag wrong");
  AST_SE0_FLAG: assert property (i_rd && i_addr == 8'h00 && steady |=> o_rdata[6] == $past(se0exp))
    else $error("se0 flag wrong");
  AST_UPPER_ZERO: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[31:8] == 24'h0)
    else $error("upper control bits not zero");
  AST_HOST_EN: assert property (hst == $past(hst) |-> o_host_role_enable == hst)
    else $error("host enable output wrong");
  AST_BIT0_SPLIT: assert property (en == $past(en) && hst == $past(hst) |->
    o_module_enable == (en && !hst) && o_frame_start_enable == (en && hst))
    else $error("bit 0 split wrong");
  AST_SETUP_HALT: assert property (!hst && i_setup_rx |-> ##[1:2] o_packet_processing_disable)
    else $error("setup did not halt packets");
  AST_TOGGLE_CLR: assert property ($changed(hst) |-> ##[0:2] !o_packet_processing_disable)
    else $error("host toggle did not clear");
  AST_BUS_RESET: assert property (bon && $past(bon) && $past(bon, 2) |-> o_oe && !o_dp && !o_dm)
    else $error("bus reset not driven");
  AST_RESUME: assert property (rc >= 3'h5 |-> o_oe && o_dp && !o_dm)
    else $error("resume not driven");
  AST_HOST_EOP: assert property (hst && !brst && $fell(res) |->
    ##[1:6] (o_oe && !o_dp && !o_dm) ##[1:EOP_MAX] !o_oe)
    else $error("end of packet missing");
  AST_DEV_NO_EOP: assert property (!hst && !brst && $fell(res) |->
    ##1 (!(o_oe && !o_dp && !o_dm))[*8])
    else $error("end of packet in device role");
endmodule : usb_ctl_monitor
bind usb_control_register_logic usb_ctl_monitor #(.EOP_CYCLES(EOP_CYCLES)) mon_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_dp(i_dp), .i_dm(i_dm), .i_low_speed(i_low_speed),
  .i_setup_rx(i_setup_rx), .o_dp(o_dp), .o_dm(o_dm), .o_oe(o_oe),
  .o_module_enable(o_module_enable), .o_frame_start_enable(o_frame_start_enable),
  .o_packet_processing_disable(o_packet_processing_disable),
  .o_host_role_enable(o_host_role_enable));
`default_nettype wire

// ==== bench/usb_remote_model.sv ====
// remote usb party: drives idle j, k or se0 unless the block drives the lines
`default_nettype none
module usb_remote_model (
  input  wire logic       i_oe,
  input  wire logic       i_dp,
  input  wire logic       i_dm,
  input  wire logic       i_ls,
  input  wire logic [1:0] i_state,
  output logic            o_dp,
  output logic            o_dm
);
  timeunit 1ns;
  timeprecision 1ns;
  // the driving block wins the wire; low speed swaps j and k polarity
  always_comb begin
    if (i_oe) begin
      {o_dp, o_dm} = {i_dp, i_dm};
    end else if (i_state == 2'h0) begin
      {o_dp, o_dm} = {!i_ls, i_ls};
    end else if (i_state == 2'h1) begin
      {o_dp, o_dm} = {i_ls, !i_ls};
    end else begin
      {o_dp, o_dm} = 2'h0;
    end
  end
endmodule : usb_remote_model
`default_nettype wire

// ==== bench/test_usb_control_register_logic.sv ====
// self-checking bench for the usb control register block
`default_nettype none
module test_usb_control_register_logic;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EOP = 4;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_low_speed = 1'b0;
  logic        i_setup_rx = 1'b0;
  logic [1:0]  st = 2'h0;
  logic [31:0] lf = 32'h0001306C;
  logic [31:0] o_rdata, dv;
  logic        i_dp, i_dm, o_dp, o_dm, o_oe, o_irq, men, fen, pkt, ppr, hen;
  int          mismatches = 0;
  int          checked = 0;
  int          n;
  always #20 i_clk = ~i_clk;
  usb_control_register_logic #(.TOKEN_CYCLES(4), .EOP_CYCLES(EOP)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_dp(i_dp), .i_dm(i_dm), .i_low_speed(i_low_speed),
    .i_setup_rx(i_setup_rx), .o_dp(o_dp), .o_dm(o_dm), .o_oe(o_oe), .o_irq(o_irq),
    .o_module_enable(men), .o_frame_start_enable(fen), .o_packet_processing_disable(pkt),
    .o_pingpong_pointer_reset(ppr), .o_host_role_enable(hen));
  usb_remote_model far_u (.i_oe(o_oe), .i_dp(o_dp), .i_dm(o_dm), .i_ls(i_low_speed),
    .i_state(st), .o_dp(i_dp), .o_dm(i_dm));
  // random source and expected live flags for a remote line state
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [31:0] flags(input logic [1:0] s);
    return (s == 2'h0) ? 32'h80 : ((s == 2'h2) ? 32'h40 : 32'h0);
  endfunction : flags
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // bus cycles: strobes last one cycle, read data sampled in the cycle after
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, dv);
    chk(dv, exp);
  endtask : rdc
  task wt(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : wt
  task setup_pulse;
    @(posedge i_clk);
    i_setup_rx <= 1'b1;
    @(posedge i_clk);
    i_setup_rx <= 1'b0;
  endtask : setup_pulse
  // hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(8'h00, 32'h80);
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      wr(8'h00, {lf[31:8], 8'h01});
      st <= lf[1:0] % 2'h3;
      i_low_speed <= lf[2];
      wt(3);
      rdc(8'h00, flags(st) | 32'h01);
      chk(men, 1);
    end
    wr(8'h00, 32'h03);
    st <= 2'h0;
    i_low_speed <= 1'b0;
    wt(3);
    chk(ppr, 1);
    wr(8'h0C, 32'hF);
    wr(8'h00, 32'h01);
    setup_pulse();
    wt(2);
    chk(pkt, 1);
    chk(o_irq, 1);
    rdc(8'h00, 32'hA1);
    rdc(8'h08, 32'h1);
    wr(8'h00, 32'h01);
    rdc(8'h00, 32'h81);
    wr(8'h10, 32'h1);
    wt(2);
    chk(o_irq, 0);
    // masked event: sticky status without the interrupt line
    wr(8'h0C, 32'h0);
    setup_pulse();
    wt(3);
    chk(o_irq, 0);
    rdc(8'h08, 32'h1);
    rdc(8'h20, 32'h0);
    wr(8'h10, 32'hF);
    wr(8'h0C, 32'hF);
    wr(8'h00, 32'h09);
    wt(2);
    chk(pkt, 0);
    chk({men, fen, hen}, 3'b011);
    rdc(8'h08, 32'h4);
    wr(8'h10, 32'hF);
    wr(8'h04, 32'h69);
    wt(1);
    rdc(8'h00, 32'hA9);
    for (n = 0; n < 12 && dv[5] !== 1'b0; n++) rd(8'h00, dv);
    chk(dv, 32'h89);
    if (dv[5] !== 1'b0) report_and_stop();
    rdc(8'h08, 32'h2);
    wr(8'h10, 32'hF);
    // a host toggle aborts a running token: no done event may follow
    wr(8'h04, 32'h2D);
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h09);
    wt(6);
    rdc(8'h08, 32'h4);
    wr(8'h10, 32'hF);
    wr(8'h00, 32'h19);
    wt(3);
    chk({o_oe, o_dp, o_dm}, 3'b100);
    rdc(8'h00, 32'h59);
    wr(8'h00, 32'h09);
    // hold times scaled down: real milliseconds would exceed the run budget
    wr(8'h00, 32'h0D);
    wt(25);
    chk({o_oe, o_dp, o_dm}, 3'b110);
    wr(8'h00, 32'h09);
    for (n = 0; n < 8 && {o_oe, o_dp, o_dm} !== 3'b100; n++) wt(1);
    if (n == 8) begin
      mismatches++;
      report_and_stop();
    end
    for (n = 0; n < 40 && {o_oe, o_dp, o_dm} === 3'b100; n++) wt(1);
    chk(n >= EOP && n <= EOP + 1, 1);
    if (n == 40) report_and_stop();
    chk(o_oe, 0);
    rdc(8'h08, 32'h8);
    wr(8'h10, 32'hF);
    wr(8'h00, 32'h05);
    wt(10);
    chk({o_oe, o_dp, o_dm}, 3'b110);
    wr(8'h00, 32'h01);
    wt(8);
    chk(o_oe, 0);
    rdc(8'h08, 32'hC);
    // reset in mid-run returns the control register to zero
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(8'h00, 32'h80);
    report_and_stop();
  end
endmodule : test_usb_control_register_logic
`default_nettype wire
